// *** mic_chk.sv ***
`timescale 1ns/100ps

module mic_chk (
	input wire        CLK_I,
	input wire        RST_I,
	input wire        HREADYOUT_O,
	input wire        HRESP_O,
	input wire        SYNTH_LOCK_I,
	input wire        SYNTH_RST_O,
	input wire [7:0]  SYNTH_MEM_DIV_O,
	input wire [9:0]  SYNTH_UI_DIV_O,
	input wire        SYNTH_INT_FB_O,
	input wire        GBUF_SYS_EN_O,
	input wire [1:0]  GBUF_HALF_DIV_O,
	input wire [9:0]  PLL_RST_O,
	input wire [9:0]  PLL_PHY_CLK_EN_O,
	input wire [6:0]  PLL_FB_PHASE_O,
	input wire        PLL_INT_FB_O,
	input wire        USER_RST_O,
	input wire        PHY_RST_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	// ----------------------------------------
	// clock structure
	// ----------------------------------------
	property p_ui_div; SYNTH_UI_DIV_O == {SYNTH_MEM_DIV_O, 2'b00}; endproperty
	a_ui_div: assert property (p_ui_div)
		else $error("user divider is not four times memory divider");
	property p_bufs; GBUF_HALF_DIV_O == 2'h2 && GBUF_SYS_EN_O == !SYNTH_RST_O; endproperty
	a_bufs: assert property (p_bufs)
		else $error("global buffer setting wrong");
	property p_phase; PLL_FB_PHASE_O == 7'h5A; endproperty
	a_phase: assert property (p_phase)
		else $error("pll feedback phase not ninety degrees");
	property p_fb; SYNTH_INT_FB_O && PLL_INT_FB_O; endproperty
	a_fb: assert property (p_fb)
		else $error("external feedback selected");

	// ----------------------------------------
	// reset sequencing
	// ----------------------------------------
	property p_pll_hold; SYNTH_RST_O |-> PLL_RST_O == 10'h3FF; endproperty
	a_pll_hold: assert property (p_pll_hold)
		else $error("pll released while synthesizer in reset");
	// release needs the lock seen one cycle and 16 cycles before it
	property p_pll_rel;
		(PLL_RST_O != 10'h3FF && $past(PLL_RST_O) == 10'h3FF)
			|-> $past(SYNTH_LOCK_I) && $past(SYNTH_LOCK_I, 16);
	endproperty
	a_pll_rel: assert property (p_pll_rel)
		else $error("pll released without qualified lock");
	property p_phy_en;
		PLL_PHY_CLK_EN_O != 10'h000 |-> (PLL_PHY_CLK_EN_O & PLL_RST_O) == 10'h000;
	endproperty
	a_phy_en: assert property (p_phy_en)
		else $error("phy clock enabled from pll in reset");
	property p_phy_rst; $fell(PHY_RST_O) |-> $past(PLL_PHY_CLK_EN_O) != 10'h000; endproperty
	a_phy_rst: assert property (p_phy_rst)
		else $error("phy reset released before locks");
	property p_user_rst; $fell(USER_RST_O) |-> !PHY_RST_O && !$past(PHY_RST_O); endproperty
	a_user_rst: assert property (p_user_rst)
		else $error("user reset released before phy reset");
	property p_bus; HREADYOUT_O && !HRESP_O; endproperty
	a_bus: assert property (p_bus)
		else $error("bus not ready or not okay");

	c_pll_rel: cover property ($fell(PLL_RST_O[0]));
	c_user: cover property ($fell(USER_RST_O));
	c_relock: cover property ($rose(PHY_RST_O));
endmodule

// *** mic_defs.vh ***
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MIC_OFS_CTRL      8'h00
`define MIC_OFS_SYNTH     8'h04
`define MIC_OFS_BANK      8'h08
`define MIC_OFS_AUX       8'h0C
`define MIC_OFS_STATUS    8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define MIC_CTRL_EN       0
`define MIC_CTRL_AUX_LO   4
`define MIC_CTRL_AUX_HI   7

// ----------------------------------------
// synthesizer config fields and reset values
// ----------------------------------------
`define MIC_SYN_D_LO      0
`define MIC_SYN_D_HI      7
`define MIC_SYN_M_LO      8
`define MIC_SYN_M_HI      15
`define MIC_SYN_O_LO      16
`define MIC_SYN_O_HI      23
`define MIC_RST_SYNTH     32'h0001_0A01

// ----------------------------------------
// bank config fields and reset values
// ----------------------------------------
`define MIC_BANKS         5
`define MIC_PLLS          10
`define MIC_BANK_USE_LO   0
`define MIC_BANK_USE_HI   4
`define MIC_BANK_SHR_LO   8
`define MIC_BANK_SHR_HI   12
`define MIC_RST_BANK      32'h0000_0001
`define MIC_RST_AUX       32'h0404_0404

// ----------------------------------------
// clocking constants
// ----------------------------------------
`define MIC_REF_KHZ       32'h0003_0D40
`define MIC_PFD_MIN_KHZ   32'h0001_1170
`define MIC_UI_RATIO      2'h2
`define MIC_HALF_DIV      2'h2
`define MIC_FB_PHASE_DEG  7'h5A
`define MIC_LOCK_QUAL     8'h10

`endif

// *** mic_far.sv ***
`timescale 1ns/100ps

module mic_far (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// controls from the block
	input  wire       synth_rst_i,
	input  wire [9:0] pll_rst_i,
	// lock delay and forced lock loss
	input  wire [7:0] dly_i,
	input  wire       drop_i,
	// locks back to the block
	output reg        synth_lock_o,
	output reg  [9:0] pll_lock_o
);
	reg [7:0] syn_q;
	reg [7:0] pll_q;

	// ----------------------------------------
	// lock models
	// ----------------------------------------
	// reference fed straight in, never through another synthesizer
	// scrubber never touched from this side
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			syn_q        <= 8'h00;
			pll_q        <= 8'h00;
			synth_lock_o <= 1'b0;
			pll_lock_o   <= 10'h000;
		end else begin
			syn_q <= (synth_rst_i || drop_i) ? 8'h00 : syn_q + {7'h0, syn_q != 8'hFF};
			pll_q <= (pll_rst_i == 10'h3FF) ? 8'h00 : pll_q + {7'h0, pll_q != 8'hFF};
			synth_lock_o <= !synth_rst_i && !drop_i && syn_q >= dly_i;
			// a pll still in reset never reports lock
			pll_lock_o <= ~pll_rst_i & {10{pll_q >= dly_i}};
		end
	end
endmodule

// *** mic_lock_qual.v ***
`timescale 1ns/100ps
`include "mic_defs.vh"

module mic_lock_qual (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// lock in and qualified lock out
	input  wire       lock_i,
	output wire       locked_o
);

	reg  [7:0] cnt_q;
	reg        locked_q;

	// a lock that bounces restarts the count, so a glitchy lock never frees the plls
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q    <= 8'h00;
			locked_q <= 1'b0;
		end else if (!lock_i) begin
			cnt_q    <= 8'h00;
			locked_q <= 1'b0;
		end else if (cnt_q == `MIC_LOCK_QUAL) begin
			locked_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign locked_o = locked_q;

endmodule

// *** mic_rst_sync.v ***
`timescale 1ns/100ps

module mic_rst_sync (
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// hold request and synchronised reset
	input  wire hold_i,
	output wire rst_o
);

	reg stage1_q;
	reg stage2_q;

	// assert at once, release only after two clean edges
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1_q <= 1'b1;
			stage2_q <= 1'b1;
		end else if (hold_i) begin
			stage1_q <= 1'b1;
			stage2_q <= 1'b1;
		end else begin
			stage1_q <= 1'b0;
			stage2_q <= stage1_q;
		end
	end

	assign rst_o = stage2_q;

endmodule

// *** mic_top.v ***
`timescale 1ns/100ps
`include "mic_defs.vh"

module mic_top (
	// clock and reset
	input  wire        CLK_I,
	input  wire        RST_I,
	// ahb-lite slave
	input  wire        HSEL_I,
	input  wire [31:0] HADDR_I,
	input  wire [1:0]  HTRANS_I,
	input  wire        HWRITE_I,
	input  wire [2:0]  HSIZE_I,
	input  wire [31:0] HWDATA_I,
	input  wire        HREADY_I,
	output wire [31:0] HRDATA_O,
	output wire        HREADYOUT_O,
	output wire        HRESP_O,
	// synthesizer control and lock
	input  wire        SYNTH_LOCK_I,
	output wire        SYNTH_RST_O,
	output wire [7:0]  SYNTH_DIVCLK_O,
	output wire [7:0]  SYNTH_MULT_O,
	output wire [7:0]  SYNTH_MEM_DIV_O,
	output wire [9:0]  SYNTH_UI_DIV_O,
	output wire [31:0] SYNTH_AUX_DIV_O,
	output wire [3:0]  SYNTH_AUX_EN_O,
	output wire        SYNTH_INT_FB_O,
	// global buffers
	output wire        GBUF_SYS_EN_O,
	output wire [1:0]  GBUF_HALF_DIV_O,
	// bank plls
	input  wire [9:0]  PLL_LOCK_I,
	output wire [9:0]  PLL_RST_O,
	output wire [9:0]  PLL_PHY_CLK_EN_O,
	output wire [6:0]  PLL_FB_PHASE_O,
	output wire        PLL_INT_FB_O,
	// downstream resets
	output wire        USER_RST_O,
	output wire        PHY_RST_O
);

	// ----------------------------------------
	// state encoding
	// ----------------------------------------
	localparam [2:0] ST_IDLE      = 3'h0;
	localparam [2:0] ST_SYN_WAIT  = 3'h1;
	localparam [2:0] ST_PLL_WAIT  = 3'h2;
	localparam [2:0] ST_READY     = 3'h3;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [31:0] ctrl_q;
	reg  [31:0] synth_q;
	reg  [31:0] bank_q;
	reg  [31:0] aux_q;
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg         cfg_err_q;
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;
	reg  [31:0] rdata_q;
	reg         syn_rst_q;
	reg  [9:0]  pll_rst_q;
	reg  [9:0]  phy_en_q;
	reg  [9:0]  ui_div_q;
	reg         gbuf_en_q;

	wire        syn_locked;
	wire [9:0]  pll_used;
	wire        plls_locked;
	wire        user_rst;
	wire        phy_rst;
	wire        addr_phase;
	wire        cfg_ok;
	wire        enable;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] reg_read;
		input [7:0] a;
		begin
			case (a)
				`MIC_OFS_CTRL:   reg_read = ctrl_q;
				`MIC_OFS_SYNTH:  reg_read = synth_q;
				`MIC_OFS_BANK:   reg_read = bank_q;
				`MIC_OFS_AUX:    reg_read = aux_q;
				`MIC_OFS_STATUS: reg_read = {PLL_LOCK_I, 14'h0000, USER_RST_O, PHY_RST_O,
					cfg_err_q, plls_locked, syn_locked, state_q};
				default:         reg_read = 32'h0000_0000;
			endcase
		end
	endfunction

	// input divider must keep the phase detector at or above its floor
	function pfd_ok;
		input [7:0] d;
		begin
			pfd_ok = (d != 8'h00) &&
				(`MIC_REF_KHZ >= (`MIC_PFD_MIN_KHZ * {24'h00_0000, d}));
		end
	endfunction

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	assign addr_phase = HSEL_I & HREADY_I & HTRANS_I[1];

	// zero wait states; unmapped reads return zero, unmapped writes are dropped
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_phase & HWRITE_I;
			wr_addr_q <= {HADDR_I[7:2], 2'h0};
			if (addr_phase && !HWRITE_I) begin
				rdata_q <= reg_read({HADDR_I[7:2], 2'h0});
			end
		end
	end

	// config writes only land while stopped, so a live clock tree never retunes
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q  <= 32'h0000_0000;
			synth_q <= `MIC_RST_SYNTH;
			bank_q  <= `MIC_RST_BANK;
			aux_q   <= `MIC_RST_AUX;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				`MIC_OFS_CTRL: begin
					ctrl_q <= {24'h00_0000, HWDATA_I[`MIC_CTRL_AUX_HI:`MIC_CTRL_AUX_LO],
						3'h0, HWDATA_I[`MIC_CTRL_EN]};
				end
				`MIC_OFS_SYNTH: begin
					if (state_q == ST_IDLE) begin
						synth_q <= {8'h00, HWDATA_I[23:0]};
					end
				end
				`MIC_OFS_BANK: begin
					if (state_q == ST_IDLE) begin
						bank_q <= {19'h0_0000, HWDATA_I[`MIC_BANK_SHR_HI:`MIC_BANK_SHR_LO],
							3'h0, HWDATA_I[`MIC_BANK_USE_HI:`MIC_BANK_USE_LO]};
					end
				end
				`MIC_OFS_AUX: begin
					if (state_q == ST_IDLE) begin
						aux_q <= HWDATA_I;
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign HRDATA_O    = rdata_q;

	// ----------------------------------------
	// configuration checks
	// ----------------------------------------
	assign enable = ctrl_q[`MIC_CTRL_EN];
	assign cfg_ok = pfd_ok(synth_q[`MIC_SYN_D_HI:`MIC_SYN_D_LO]) &&
		(synth_q[`MIC_SYN_M_HI:`MIC_SYN_M_LO] != 8'h00) &&
		(synth_q[`MIC_SYN_O_HI:`MIC_SYN_O_LO] != 8'h00) &&
		(bank_q[`MIC_BANK_USE_HI:`MIC_BANK_USE_LO] != 5'h00);

	// ----------------------------------------
	// pll usage per bank
	// ----------------------------------------
	genvar b;
	generate
		for (b = 0; b < `MIC_BANKS; b = b + 1) begin : g_bank
			assign pll_used[2*b]   = bank_q[`MIC_BANK_USE_LO + b];
			assign pll_used[2*b+1] = bank_q[`MIC_BANK_USE_LO + b] &
				bank_q[`MIC_BANK_SHR_LO + b];
		end
	endgenerate

	assign plls_locked = ((PLL_LOCK_I & pll_used) == pll_used) && syn_locked;

	mic_lock_qual u_lock_qual (
		.clk_i    (CLK_I),
		.rst_i    (RST_I),
		.lock_i   (SYNTH_LOCK_I),
		.locked_o (syn_locked)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (enable && cfg_ok) begin
					state_d = ST_SYN_WAIT;
				end
			end
			ST_SYN_WAIT: begin
				if (!enable) begin
					state_d = ST_IDLE;
				end else if (syn_locked) begin
					state_d = ST_PLL_WAIT;
				end
			end
			ST_PLL_WAIT: begin
				if (!enable) begin
					state_d = ST_IDLE;
				end else if (!syn_locked) begin
					state_d = ST_SYN_WAIT;
				end else if (plls_locked) begin
					state_d = ST_READY;
				end
			end
			ST_READY: begin
				if (!enable) begin
					state_d = ST_IDLE;
				end else if (!syn_locked) begin
					state_d = ST_SYN_WAIT;
				end else if (!plls_locked) begin
					state_d = ST_PLL_WAIT;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// synthesizer lock loss drops straight back, re-holding every pll before it can misbehave; pll lock loss alone keeps the used plls released
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q   <= ST_IDLE;
			cfg_err_q <= 1'b0;
			syn_rst_q <= 1'b1;
			pll_rst_q <= 10'h3FF;
			phy_en_q  <= 10'h000;
			ui_div_q  <= 10'h000;
			gbuf_en_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cfg_err_q <= enable & ~cfg_ok & (state_q == ST_IDLE);
			syn_rst_q <= (state_d == ST_IDLE);
			// same idle window as the memory divider, so the pair never disagrees
			if (state_q == ST_IDLE) begin
				ui_div_q <= {2'h0, synth_q[`MIC_SYN_O_HI:`MIC_SYN_O_LO]} << `MIC_UI_RATIO;
			end
			gbuf_en_q <= (state_d != ST_IDLE);
			if ((state_d == ST_PLL_WAIT) || (state_d == ST_READY)) begin
				pll_rst_q <= ~pll_used;
			end else begin
				pll_rst_q <= 10'h3FF;
			end
			if (state_d == ST_READY) begin
				phy_en_q <= pll_used;
			end else begin
				phy_en_q <= 10'h000;
			end
		end
	end

	// ----------------------------------------
	// downstream resets
	// ----------------------------------------
	mic_rst_sync u_phy_rst (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.hold_i (state_q != ST_READY),
		.rst_o  (phy_rst)
	);

	mic_rst_sync u_user_rst (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.hold_i (phy_rst),
		.rst_o  (user_rst)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	reg  [31:0] aux_div_q;
	reg  [3:0]  aux_en_q;
	reg  [23:0] syn_cfg_q;

	// factors only move to the synthesizer while it is held in reset
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			aux_div_q <= 32'h0000_0000;
			aux_en_q  <= 4'h0;
			syn_cfg_q <= 24'h00_0000;
		end else if (state_q == ST_IDLE) begin
			aux_div_q <= aux_q;
			aux_en_q  <= ctrl_q[`MIC_CTRL_AUX_HI:`MIC_CTRL_AUX_LO];
			syn_cfg_q <= synth_q[23:0];
		end
	end

	assign SYNTH_RST_O      = syn_rst_q;
	assign SYNTH_DIVCLK_O   = syn_cfg_q[7:0];
	assign SYNTH_MULT_O     = syn_cfg_q[15:8];
	assign SYNTH_MEM_DIV_O  = syn_cfg_q[23:16];
	assign SYNTH_UI_DIV_O   = ui_div_q;
	assign SYNTH_AUX_DIV_O  = aux_div_q;
	assign SYNTH_AUX_EN_O   = aux_en_q;
	assign GBUF_SYS_EN_O    = gbuf_en_q;
	assign PLL_RST_O        = pll_rst_q;
	assign PLL_PHY_CLK_EN_O = phy_en_q;
	assign USER_RST_O       = user_rst;
	assign PHY_RST_O        = phy_rst;

	// fixed structural settings, held in flops so every output is registered
	reg        int_fb_q;
	reg [6:0]  phase_q;
	reg [1:0]  half_q;
	reg        rdy_q;
	reg        resp_q;

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			int_fb_q <= 1'b1;
			phase_q  <= `MIC_FB_PHASE_DEG;
			half_q   <= `MIC_HALF_DIV;
			rdy_q    <= 1'b1;
			resp_q   <= 1'b0;
		end else begin
			int_fb_q <= 1'b1;
			phase_q  <= `MIC_FB_PHASE_DEG;
			half_q   <= `MIC_HALF_DIV;
			rdy_q    <= 1'b1;
			resp_q   <= 1'b0;
		end
	end

	assign SYNTH_INT_FB_O  = int_fb_q;
	assign PLL_INT_FB_O    = int_fb_q;
	assign PLL_FB_PHASE_O  = phase_q;
	assign GBUF_HALF_DIV_O = half_q;
	assign HREADYOUT_O     = rdy_q;
	assign HRESP_O         = resp_q;

endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} mic_row_t;
	logic        clk, rst, hsel, hwr, slock, drop;
	logic [1:0]  htr;
	logic [31:0] hadr, hwd, hrd, aux, r;
	logic        hrdy, hresp, srst, sfb, gen, pfb, ursr, prst;
	logic [7:0]  sd, sm, so, dly;
	logic [9:0]  sui, plock, prs, pen;
	logic [3:0]  aen;
	logic [1:0]  hdiv;
	logic [6:0]  ph;
	int          bad_count, samples_checked, cyc, n, i;
	mic_row_t    rows [0:13];
	logic [31:0] exps [0:13];

	mic_top mic_top_inst (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(hadr),
		.HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hrdy),
		.HRDATA_O(hrd), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .SYNTH_LOCK_I(slock),
		.SYNTH_RST_O(srst), .SYNTH_DIVCLK_O(sd), .SYNTH_MULT_O(sm), .SYNTH_MEM_DIV_O(so),
		.SYNTH_UI_DIV_O(sui), .SYNTH_AUX_DIV_O(aux), .SYNTH_AUX_EN_O(aen),
		.SYNTH_INT_FB_O(sfb), .GBUF_SYS_EN_O(gen), .GBUF_HALF_DIV_O(hdiv),
		.PLL_LOCK_I(plock), .PLL_RST_O(prs), .PLL_PHY_CLK_EN_O(pen),
		.PLL_FB_PHASE_O(ph), .PLL_INT_FB_O(pfb), .USER_RST_O(ursr), .PHY_RST_O(prst));
	mic_far mic_far_inst (.clk_i(clk), .rst_i(rst), .synth_rst_i(srst), .pll_rst_i(prs),
		.dly_i(dly), .drop_i(drop), .synth_lock_o(slock), .pll_lock_o(plock));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1; htr <= 2'h2; hwr <= w; hadr <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0; htr <= 2'h0; hwd <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrd;
	endtask
	// bounded wait on one of the reset outputs
	task wt(input int s, input logic v);
		n = 0;
		while ((s == 0 ? ursr : s == 1 ? prst : srst) !== v && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task run(input logic [7:0] dl);
		dly <= dl;
		bus(1'b1, 8'h00, 32'h0000_00F1);
		wt(0, 1'b0);
		chk(prs, 10'h3F8);
		chk(pen, 10'h007);
		chk({gen, aen}, 5'h1F);
		bus(1'b0, 8'h10, 32'h0);
		chk({r[31:22], r[4:3]}, 12'h01F);
		bus(1'b1, 8'h04, 32'h0000_0101);
		bus(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0003_0C02);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1; hsel = 1'b0; htr = 2'h0; hwr = 1'b0; hadr = 32'h0; hwd = 32'h0;
		dly = 8'h02; drop = 1'b0;
		rows = '{'{0, 8'h00, 0}, '{0, 8'h04, 0}, '{0, 8'h08, 0}, '{0, 8'h0C, 0},
			'{1, 8'h20, 32'hDEAD_BEEF}, '{0, 8'h20, 0}, '{1, 8'h04, 32'h0003_0C02},
			'{0, 8'h04, 0}, '{1, 8'h10, 32'hFFFF_FFFF}, '{0, 8'h10, 0},
			'{1, 8'h08, 32'h0000_0103}, '{0, 8'h08, 0}, '{1, 8'h0C, 32'h1122_3344},
			'{0, 8'h0C, 0}};
		exps = '{0, 32'h0001_0A01, 1, 32'h0404_0404, 0, 0, 0, 32'h0003_0C02, 0,
			32'h0000_00C0, 0, 32'h0000_0103, 0, 32'h1122_3344};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk({srst, prs, pen, ursr, prst}, {1'b1, 10'h3FF, 10'h000, 2'b11});
		for (i = 0; i < 14; i++) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk(r, exps[i]);
		end
		chk({sd, sm, so, sui}, {8'h02, 8'h0C, 8'h03, 10'h00C});
		chk(aux, 32'h1122_3344);
		chk({sfb, pfb, ph, hdiv, hresp}, {2'b11, 7'h5A, 2'h2, 1'b0});
		$display("test registers done");
		run(8'h02);
		drop <= 1'b1;
		wt(0, 1'b1);
		chk({prs, pen, prst}, {10'h3FF, 10'h000, 1'b1});
		drop <= 1'b0;
		wt(0, 1'b0);
		chk(pen, 10'h007);
		$display("test lock loss done");
		bus(1'b1, 8'h00, 32'h0);
		wt(2, 1'b1);
		chk(prs, 10'h3FF);
		run(8'h28);
		$display("test slow locks done");
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		chk({srst, prs, ursr, prst}, {1'b1, 10'h3FF, 2'b11});
		rst <= 1'b0;
		bus(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0001_0A01);
		bus(1'b1, 8'h04, 32'h0001_0A03);
		bus(1'b1, 8'h00, 32'h0000_0001);
		bus(1'b0, 8'h10, 32'h0);
		chk({r[5], srst}, 2'b11);
		$display("test reset and config error done");
		final_report;
	end

endmodule

bind mic_top mic_chk mic_chk_inst (.CLK_I(CLK_I), .RST_I(RST_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SYNTH_LOCK_I(SYNTH_LOCK_I),
	.SYNTH_RST_O(SYNTH_RST_O), .SYNTH_MEM_DIV_O(SYNTH_MEM_DIV_O),
	.SYNTH_UI_DIV_O(SYNTH_UI_DIV_O), .SYNTH_INT_FB_O(SYNTH_INT_FB_O),
	.GBUF_SYS_EN_O(GBUF_SYS_EN_O), .GBUF_HALF_DIV_O(GBUF_HALF_DIV_O),
	.PLL_RST_O(PLL_RST_O), .PLL_PHY_CLK_EN_O(PLL_PHY_CLK_EN_O),
	.PLL_FB_PHASE_O(PLL_FB_PHASE_O), .PLL_INT_FB_O(PLL_INT_FB_O),
	.USER_RST_O(USER_RST_O), .PHY_RST_O(PHY_RST_O));
